/* hw/link_ctrl.sv */
// Balanced extended-sequence link frame controller with its transmit FIFO.
`timescale 1ns/1ns
`include "link_ctrl_map.svh"

// Synchronous FIFO with valid/ready on both sides.
module link_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,      // Clock.
  input  wire logic             reset_n_i,  // Asynchronous reset, active low.
  input  wire logic             in_valid_i, // Write request.
  output logic                  in_ready_o, // Space available.
  input  wire logic [WIDTH-1:0] in_data_i,  // Write data.
  output logic                  out_valid_o,// Data available.
  input  wire logic             out_ready_i,// Consumer takes data.
  output logic      [WIDTH-1:0] out_data_o, // Read data.
  output logic [$clog2(DEPTH):0] level_o    // Words held.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic             push;
  logic             pop;

  // Handshakes and flags come from the fill level.
  assign in_ready_o  = (level_o < (AW+1)'(DEPTH));
  assign out_valid_o = (level_o != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem[rd_ptr];

  // Storage write.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers and level.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      level_o <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop) level_o <= level_o + 1'b1;
      else if (pop && !push) level_o <= level_o - 1'b1;
    end
  end
endmodule // link_fifo

// Frame controller: decodes received frames, keeps link phase and queues answers.
module link_ctrl (
  input  wire logic                  clk_i,          // 100 MHz clock.
  input  wire logic                  reset_n_i,      // Asynchronous reset, active low.
  input  wire logic                  calling_i,      // This end originated the bearer.
  input  wire logic                  connect_req_i,  // Level: request link set-up.
  input  wire logic                  disc_req_i,     // Level: request disconnection.
  input  wire logic                  busy_i,         // Local receiver cannot take I frames.
  input  wire logic                  timeout_i,      // Pulse: acknowledgement timer expired.
  input  wire logic [6:0]            vs_i,           // Current send state variable.
  input  wire logic                  rx_valid_i,     // Received frame present.
  output logic                       rx_ready_o,     // Frame may be taken.
  input  wire logic [7:0]            rx_addr_i,      // Received address octet.
  input  wire logic [15:0]           rx_ctrl_i,      // Received control field.
  input  wire logic                  rx_bad_i,       // Received frame malformed.
  output link_ctrl_pkg::phase_t      phase_o,        // Link phase.
  output logic [6:0]                 vr_o,           // Receive state variable.
  output logic                       deliver_o,      // Pulse: pass I field upward.
  output logic                       out_of_seq_o,   // Pulse: delivered field is out of order.
  output logic                       retx_o,         // Pulse: start retransmission.
  output logic [6:0]                 retx_nr_o,      // First frame to resend.
  output logic                       frmr_event_o,   // Pulse: frame reject raised or seen.
  output logic [39:0]                frmr_info_o,    // Frame-reject field, octet 1 low.
  output logic                       busy_o,         // Local busy condition.
  output logic                       peer_busy_o,    // Peer reported RNR.
  output logic                       tx_bit_o,       // Serial header bit.
  output logic                       tx_bit_valid_o, // Serial bit present.
  input  wire logic                  tx_bit_ready_i  // Line takes the bit.
);
  import link_ctrl_pkg::*;

  logic [7:0]  own_cmd;
  logic [7:0]  peer_cmd;
  logic        dte;
  logic        take;
  logic        is_cmd;
  logic        is_rsp;
  logic [7:0]  ucode;
  logic [7:0]  scode;
  logic        pf;
  logic [6:0]  ns;
  logic [6:0]  nr;
  logic        srej_sent;
  logic        tx_en;
  logic        tx_cmd;
  logic        tx_u;
  logic [15:0] tx_ctrl;
  logic        fifo_ready;
  logic        fifo_valid;
  logic [24:0] fifo_data;
  logic [4:0]  fifo_level;
  logic [23:0] shift;
  logic [4:0]  cnt;
  phase_t      next_phase;
  logic        next_frmr;
  logic        next_deliver;
  logic        next_oos;
  logic        next_retx;
  logic        next_vr_inc;
  logic        next_srej;
  logic        next_peer_busy;
  logic        next_busy;

  // Role and addresses; only one link exists, so no link selection.
  assign own_cmd  = dte ? `ADDR_A : `ADDR_B;
  assign peer_cmd = dte ? `ADDR_B : `ADDR_A;
  assign take     = rx_valid_i && rx_ready_o;
  assign is_cmd   = (rx_addr_i == peer_cmd);
  assign is_rsp   = (rx_addr_i == own_cmd);
  assign ucode    = rx_ctrl_i[7:0] & `U_MASK;
  assign scode    = rx_ctrl_i[7:0] & `S_MASK;
  assign pf       = (rx_ctrl_i[1:0] == 2'h3) ? rx_ctrl_i[`U_PF_BIT] : rx_ctrl_i[8];
  assign ns       = rx_ctrl_i[7:1];
  assign nr       = rx_ctrl_i[15:9];

  // Frame decision: what to queue and how phase and counters move.
  always_comb begin
    tx_en = 1'b0; tx_cmd = 1'b0; tx_u = 1'b0; tx_ctrl = 16'h0000;
    next_phase = phase_o; next_frmr = 1'b0; next_deliver = 1'b0; next_oos = 1'b0;
    next_retx = timeout_i; next_vr_inc = 1'b0; next_srej = srej_sent;
    next_peer_busy = peer_busy_o; next_busy = busy_o;
    if (take && !rx_bad_i && (is_cmd || is_rsp)) begin
      if (rx_ctrl_i[1:0] == 2'h3) begin
        tx_u = 1'b1;
        if (ucode == `U_SABME && is_cmd) begin
          tx_en = 1'b1;
          if (phase_o == PH_IDLE) begin
            tx_ctrl = {8'h00, `U_UA | {3'h0, pf, 4'h0}};
            next_phase = PH_INFO;
          end else begin
            tx_cmd = 1'b1; // No link reset mid-transfer: close instead.
            tx_ctrl = {8'h00, `U_DISC};
            next_phase = PH_CLOSING;
          end
        end else if (ucode == `U_DISC && is_cmd) begin
          tx_en = 1'b1;
          tx_ctrl = {8'h00, ((phase_o == PH_IDLE) ? `U_DM : `U_UA) | {3'h0, pf, 4'h0}};
          next_phase = PH_IDLE;
        end else if (ucode == `U_UA && is_rsp) begin
          if (phase_o == PH_SETUP) next_phase = PH_INFO;
          else if (phase_o == PH_CLOSING) next_phase = PH_IDLE;
        end else if (ucode == `U_DM && is_rsp) begin
          next_phase = PH_IDLE;
        end else if (ucode == `U_FRMR && is_rsp && phase_o != PH_IDLE) begin
          tx_en = 1'b1; tx_cmd = 1'b1; tx_ctrl = {8'h00, `U_DISC};
          next_frmr = 1'b1; next_phase = PH_CLOSING;
        end else if (phase_o != PH_IDLE) begin
          tx_en = 1'b1; tx_ctrl = {8'h00, `U_FRMR};
          next_frmr = 1'b1; next_phase = PH_REJECTED;
        end else if (is_cmd && pf) begin
          tx_en = 1'b1; tx_ctrl = {8'h00, `U_DM | 8'h10};
        end
      end else if (phase_o == PH_INFO) begin
        if (rx_ctrl_i[1:0] == 2'h1) begin
          if (scode == `S_REJ) begin
            tx_en = 1'b1; tx_u = 1'b1; tx_ctrl = {8'h00, `U_FRMR};
            next_frmr = 1'b1; next_phase = PH_REJECTED;
          end else if (scode == `S_SREJ) begin
            next_retx = 1'b1;
          end else begin
            next_peer_busy = (scode == `S_RNR);
            if (is_rsp && pf) next_retx = 1'b1;
            if (is_cmd && pf) begin
              tx_en = 1'b1;
              tx_ctrl = {vr_o, 1'b1, busy_o ? `S_RNR : `S_RR};
            end
          end
        end else if (!(is_rsp && !pf)) begin
          next_deliver = 1'b1;
          tx_en = 1'b1;
          if (ns == vr_o) begin
            next_vr_inc = 1'b1; next_srej = 1'b0;
            tx_ctrl = {vr_o + 7'h01, is_cmd & pf, busy_o ? `S_RNR : `S_RR};
          end else begin
            next_oos = 1'b1;
            tx_en = !srej_sent;
            next_srej = 1'b1;
            tx_ctrl = {vr_o, 1'b0, `S_SREJ};
          end
        end
      end else if (phase_o == PH_IDLE && is_cmd && pf) begin
        tx_en = 1'b1; tx_u = 1'b1; tx_ctrl = {8'h00, `U_DM | 8'h10};
      end
    end else if (!take && fifo_ready) begin
      if (connect_req_i && dte && phase_o == PH_IDLE) begin
        tx_en = 1'b1; tx_cmd = 1'b1; tx_u = 1'b1;
        tx_ctrl = {8'h00, `U_SABME};
        next_phase = PH_SETUP;
      end else if (disc_req_i && (phase_o == PH_INFO || phase_o == PH_REJECTED)) begin
        tx_en = 1'b1; tx_cmd = 1'b1; tx_u = 1'b1;
        tx_ctrl = {8'h00, `U_DISC};
        next_phase = PH_CLOSING;
      end else if (phase_o == PH_INFO && busy_i != busy_o) begin
        tx_en = 1'b1; next_busy = busy_i;
        tx_ctrl = {vr_o, 1'b0, busy_i ? `S_RNR : `S_RR};
      end
    end
  end

  // Role capture while no link exists.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) dte <= 1'b0;
    else if (phase_o == PH_IDLE) dte <= calling_i;
  end

  // Phase, sequence and condition state.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_o <= PH_IDLE; vr_o <= 7'h00; srej_sent <= 1'b0;
      busy_o <= 1'b0; peer_busy_o <= 1'b0;
    end else begin
      phase_o <= next_phase;
      srej_sent <= next_srej;
      busy_o <= (next_phase == PH_INFO) ? next_busy : 1'b0;
      peer_busy_o <= next_peer_busy;
      if (next_phase == PH_IDLE) vr_o <= 7'h00;
      else if (next_vr_inc) vr_o <= vr_o + 7'h01;
    end
  end

  // Event pulses and the frame-reject field.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      deliver_o <= 1'b0; out_of_seq_o <= 1'b0; retx_o <= 1'b0; retx_nr_o <= 7'h00;
      frmr_event_o <= 1'b0; frmr_info_o <= 40'h00_0000_0000; rx_ready_o <= 1'b0;
    end else begin
      deliver_o <= next_deliver;
      out_of_seq_o <= next_oos;
      retx_o <= next_retx && phase_o == PH_INFO;
      if (next_retx && take) retx_nr_o <= nr;
      frmr_event_o <= next_frmr;
      if (next_frmr && tx_ctrl[7:0] == `U_FRMR) begin
        frmr_info_o <= {8'h01 << `FRMR_W_BIT, vr_o, is_rsp, vs_i, 1'b0, rx_ctrl_i};
      end
      rx_ready_o <= (fifo_level < 5'(`FIFO_DEPTH - 2));
    end
  end

  link_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) tx_q (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .in_valid_i (tx_en),
    .in_ready_o (fifo_ready),
    .in_data_i  ({tx_u, tx_ctrl, tx_cmd ? own_cmd : peer_cmd}),
    .out_valid_o(fifo_valid),
    .out_ready_i(!tx_bit_valid_o),
    .out_data_o (fifo_data),
    .level_o    (fifo_level)
  );

  // Header serialiser: address then control, each octet bit 0 first.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shift <= 24'h00_0000; cnt <= 5'h00; tx_bit_o <= 1'b0; tx_bit_valid_o <= 1'b0;
    end else if (!tx_bit_valid_o) begin
      if (fifo_valid) begin
        tx_bit_o <= fifo_data[0];
        shift <= {1'b0, fifo_data[23:1]};
        cnt <= (fifo_data[24] ? `BITS_U : `BITS_S) - 5'h01;
        tx_bit_valid_o <= 1'b1;
      end
    end else if (tx_bit_ready_i) begin
      if (cnt != 5'h00) begin
        tx_bit_o <= shift[0];
        shift <= {1'b0, shift[23:1]};
        cnt <= cnt - 5'h01;
      end else begin
        tx_bit_valid_o <= 1'b0;
      end
    end
  end

  // Checks on the controller's own decisions.
  sequence s_rx_ok;
    take && !rx_bad_i && phase_o == PH_INFO;
  endsequence
  sequence s_peer_frmr;
    take && !rx_bad_i && phase_o != PH_IDLE && is_rsp && rx_ctrl_i[1:0] == 2'h3 && ucode == `U_FRMR;
  endsequence
  a_no_sabm_sent: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    tx_en && tx_u |-> tx_ctrl[7:0] != `U_SABM) else $error("SABM queued");
  a_no_rej_sent: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    tx_en && !tx_u |-> (tx_ctrl[7:0] & `S_MASK) != `S_REJ) else $error("REJ queued");
  a_dm_solicited: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    tx_en && tx_u && (tx_ctrl[7:0] & `U_MASK) == `U_DM |-> take && is_cmd)
    else $error("unsolicited DM");
  a_rej_frmr: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_rx_ok ##0 is_cmd && rx_ctrl_i[1:0] == 2'h1 && scode == `S_REJ
    |=> frmr_event_o && frmr_info_o[32] && phase_o == PH_REJECTED) else $error("REJ not rejected");
  a_srej_accepted: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_rx_ok ##0 rx_ctrl_i[1:0] == 2'h1 && scode == `S_SREJ |=> !frmr_event_o ##1 !frmr_event_o)
    else $error("SREJ rejected");
  a_bad_ignored: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    take && rx_bad_i |=> $stable(vr_o) && $stable(phase_o) && !deliver_o) else $error("bad frame used");
  a_frmr_disc: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_peer_frmr |-> tx_en && tx_cmd ##1 phase_o == PH_CLOSING) else $error("FRMR not closed");
  a_oos_kept: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_rx_ok ##0 !rx_ctrl_i[0] && is_cmd && ns != vr_o |=> deliver_o && out_of_seq_o && $stable(vr_o))
    else $error("out-of-order field lost");
  a_retx_cause: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    retx_o |-> $past(timeout_i) || $past(take && rx_ctrl_i[1:0] == 2'h1)) else $error("bad retransmit");
  a_busy_signal: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !take && fifo_ready && phase_o == PH_INFO && busy_i && !busy_o && !connect_req_i && !disc_req_i
    |-> tx_en && tx_ctrl[7:0] == `S_RNR ##1 busy_o) else $error("busy not signalled");
endmodule // link_ctrl

/* inc/link_ctrl_map.svh */
// Address, control-field, frame-reject layout and sizing constants for the link controller.
`ifndef LINK_CTRL_MAP_SVH
`define LINK_CTRL_MAP_SVH
`define ADDR_A      8'h03
`define ADDR_B      8'h01
`define U_MASK      8'hef
`define U_PF_BIT    4
`define U_SABME     8'h6f
`define U_SABM      8'h2f
`define U_DISC      8'h43
`define U_UA        8'h63
`define U_DM        8'h0f
`define U_FRMR      8'h87
`define U_UI        8'h03
`define S_MASK      8'h0f
`define S_RR        8'h01
`define S_RNR       8'h05
`define S_REJ       8'h09
`define S_SREJ      8'h0d
`define FRMR_W_BIT  0
`define FIFO_DEPTH  16
`define FIFO_WIDTH  25
`define BITS_U      5'h10
`define BITS_S      5'h18
`endif

/* inc/link_ctrl_pkg.sv */
// Types shared by the link controller.
package link_ctrl_pkg;
  typedef enum logic [2:0] {
    PH_IDLE     = 3'b000,
    PH_SETUP    = 3'b001,
    PH_INFO     = 3'b010,
    PH_REJECTED = 3'b011,
    PH_CLOSING  = 3'b100
  } phase_t;
endpackage

/* verif/link_ctrl_tb.sv */
// Self-checking bench for the link frame controller against the far-end model.
`timescale 1ns/1ns
`include "link_ctrl_map.svh"
module link_ctrl_tb;
  import link_ctrl_pkg::*;
  logic        clk_i = 1'b0, reset_n_i = 1'b0, calling_i = 1'b0, connect_req_i = 1'b0;
  logic        disc_req_i = 1'b0, busy_i = 1'b0, timeout_i = 1'b0, hold = 1'b0, slow = 1'b0;
  logic [6:0]  vs_i = 7'h00, vr_o, retx_nr_o;
  logic [7:0]  rx_addr_i;
  logic [15:0] rx_ctrl_i;
  logic [39:0] frmr_info_o;
  logic        rx_valid_i, rx_ready_o, rx_bad_i, deliver_o, out_of_seq_o, retx_o, frmr_event_o;
  logic        busy_o, peer_busy_o, tx_bit_o, tx_bit_valid_o, tx_bit_ready_i, seen;
  phase_t      phase_o;
  int          mismatches = 0, n_compared = 0, cycles = 0, n;

  link_ctrl link_ctrl_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .calling_i(calling_i),
    .connect_req_i(connect_req_i), .disc_req_i(disc_req_i), .busy_i(busy_i),
    .timeout_i(timeout_i), .vs_i(vs_i), .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o),
    .rx_addr_i(rx_addr_i), .rx_ctrl_i(rx_ctrl_i), .rx_bad_i(rx_bad_i), .phase_o(phase_o),
    .vr_o(vr_o), .deliver_o(deliver_o), .out_of_seq_o(out_of_seq_o), .retx_o(retx_o),
    .retx_nr_o(retx_nr_o), .frmr_event_o(frmr_event_o), .frmr_info_o(frmr_info_o),
    .busy_o(busy_o), .peer_busy_o(peer_busy_o), .tx_bit_o(tx_bit_o),
    .tx_bit_valid_o(tx_bit_valid_o), .tx_bit_ready_i(tx_bit_ready_i));
  link_peer link_peer_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .tx_bit_i(tx_bit_o),
    .tx_bit_valid_i(tx_bit_valid_o), .tx_bit_ready_o(tx_bit_ready_i), .hold_i(hold),
    .slow_i(slow), .rx_ready_i(rx_ready_o), .rx_valid_o(rx_valid_i), .rx_addr_o(rx_addr_i),
    .rx_ctrl_o(rx_ctrl_i), .rx_bad_o(rx_bad_i));

  // Clock and hang guard.
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int k = 1);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  task automatic put(input logic [7:0] a, input logic [15:0] c, input logic b = 1'b0);
    link_peer_inst.send(a, c, b);
  endtask

  // Wait a bounded time for the next frame on the line, then judge length and bits.
  task automatic frame(input logic [7:0] len, input logic [23:0] exp, input logic [23:0] m);
    logic [31:0] f;
    repeat (300) if (link_peer_inst.frames.size() == 0) step();
    f = (link_peer_inst.frames.size() != 0) ? link_peer_inst.frames.pop_front() : 32'h0;
    check(40'(f[31:24]), 40'(len));
    check(40'(f[23:0] & m), 40'(exp));
  endtask

  // Called end answers SABME with UA and polls with RR; junk is ignored.
  task automatic t_dce_link();
    put(`ADDR_A, {8'h00, `U_SABME | 8'h10});
    step();
    check(40'(phase_o), 40'(PH_INFO));
    frame(8'd16, {8'h00, `U_UA | 8'h10, `ADDR_A}, 24'hffffff);
    put(`ADDR_A, 16'h0101);
    frame(8'd24, {8'h01, `S_RR, `ADDR_A}, 24'hffffff);
    put(`ADDR_A, 16'h0101, 1'b1);
    put(8'h55, 16'h0101);
    step(60);
    check(40'(link_peer_inst.frames.size()), 40'h0);
    check(40'({vr_o, phase_o}), 40'({7'h00, PH_INFO}));
  endtask

  // Received REJ raises a frame reject; a peer FRMR leads to DISC, then DM in idle.
  task automatic t_frmr();
    vs_i = 7'h2a;
    put(`ADDR_A, {8'h00, `S_REJ});
    check(40'({frmr_event_o, phase_o}), 40'({1'b1, PH_REJECTED}));
    check(frmr_info_o, {8'h01, 7'h00, 1'b0, 7'h2a, 1'b0, 16'h0009});
    frame(8'd16, {8'h00, `U_FRMR, `ADDR_A}, 24'h00efff);
    put(`ADDR_B, {8'h00, `U_FRMR});
    check(40'({frmr_event_o, phase_o}), 40'({1'b1, PH_CLOSING}));
    frame(8'd16, {8'h00, `U_DISC, `ADDR_B}, 24'h00efff);
    put(`ADDR_B, {8'h00, `U_UA | 8'h10});
    step();
    check(40'(phase_o), 40'(PH_IDLE));
    put(`ADDR_A, {8'h00, `U_DISC | 8'h10});
    frame(8'd16, {8'h00, `U_DM | 8'h10, `ADDR_A}, 24'hffffff);
  endtask

  // Calling end sets up, then sequence errors, recovery, busy, UI and disconnect.
  task automatic t_dte();
    calling_i = 1'b1;
    connect_req_i = 1'b1;
    step(2);
    connect_req_i = 1'b0;
    check(40'(phase_o), 40'(PH_SETUP));
    frame(8'd16, {8'h00, `U_SABME, `ADDR_A}, 24'h00efff);
    put(`ADDR_A, {8'h00, `U_UA | 8'h10});
    step();
    check(40'(phase_o), 40'(PH_INFO));
    put(`ADDR_B, 16'h0000);
    check(40'({deliver_o, out_of_seq_o, vr_o}), 40'({2'b10, 7'h01}));
    frame(8'd24, {8'h02, `S_RR, `ADDR_B}, 24'hffffff);
    put(`ADDR_A, 16'h0002);
    check(40'(deliver_o), 40'h0);
    put(`ADDR_B, 16'h000a);
    check(40'({deliver_o, out_of_seq_o, vr_o}), 40'({2'b11, 7'h01}));
    frame(8'd24, {8'h02, `S_SREJ, `ADDR_B}, 24'hffffff);
    put(`ADDR_A, 16'h060d);
    check(40'({retx_o, retx_nr_o, phase_o}), 40'({1'b1, 7'h03, PH_INFO}));
    timeout_i = 1'b1;
    step();
    timeout_i = 1'b0;
    seen = retx_o;
    step();
    check(40'({seen, retx_o}), 40'h2);
    put(`ADDR_A, 16'h0501);
    check(40'({retx_o, retx_nr_o}), 40'({1'b1, 7'h02}));
    busy_i = 1'b1;
    frame(8'd24, {8'h02, `S_RNR, `ADDR_B}, 24'hffffff);
    check(40'(busy_o), 40'h1);
    busy_i = 1'b0;
    frame(8'd24, {8'h02, `S_RR, `ADDR_B}, 24'hffffff);
    put(`ADDR_B, 16'h0205);
    step();
    check(40'(peer_busy_o), 40'h1);
    put(`ADDR_B, {8'h00, `U_UI});
    step();
    check(40'({frmr_info_o[32], phase_o}), 40'({1'b1, PH_REJECTED}));
    frame(8'd16, {8'h00, `U_FRMR, `ADDR_B}, 24'h00efff);
    disc_req_i = 1'b1;
    frame(8'd16, {8'h00, `U_DISC, `ADDR_A}, 24'h00efff);
    disc_req_i = 1'b0;
    put(`ADDR_A, {8'h00, `U_UA | 8'h10});
    step();
    check(40'(phase_o), 40'(PH_IDLE));
  endtask

  // Stall the line until frames are refused, then drain slowly and count answers.
  task automatic t_fifo();
    calling_i = 1'b0;
    hold = 1'b1;
    n = 0;
    put(`ADDR_A, {8'h00, `U_SABME});
    while (rx_ready_o && n < 24) begin
      put(`ADDR_A, 16'h0101);
      n++;
      step(2);
    end
    check(40'({rx_ready_o, n < 24}), 40'h1);
    hold = 1'b0;
    slow = 1'b1;
    frame(8'd16, {8'h00, `U_UA, `ADDR_A}, 24'hffffff);
    repeat (n) frame(8'd24, {8'h01, `S_RR, `ADDR_A}, 24'hffffff);
    check(40'(rx_ready_o), 40'h1);
  endtask

  // Main sequence.
  initial begin
    step(2);
    reset_n_i = 1'b1;
    step(2);
    check(40'({busy_o, peer_busy_o, frmr_event_o, phase_o, rx_ready_o}), 40'h1);
    t_dce_link();
    t_frmr();
    t_dte();
    t_fifo();
    final_report();
  end
endmodule // link_ctrl_tb

/* verif/link_peer.sv */
// Far-end link entity model: takes serial header bits and offers received frames.
`timescale 1ns/1ns
module link_peer (
  input  wire logic        clk_i,          // Clock.
  input  wire logic        reset_n_i,      // Reset, active low.
  input  wire logic        tx_bit_i,       // Serial bit from the controller.
  input  wire logic        tx_bit_valid_i, // Serial bit present.
  output logic             tx_bit_ready_o, // Bit taken.
  input  wire logic        hold_i,         // Stall the line completely.
  input  wire logic        slow_i,         // Take a bit every other cycle.
  input  wire logic        rx_ready_i,     // Controller takes a frame.
  output logic             rx_valid_o,     // Frame present.
  output logic [7:0]       rx_addr_o,      // Address octet.
  output logic [15:0]      rx_ctrl_o,      // Control field.
  output logic             rx_bad_o        // Malformed frame.
);
  logic [31:0] frames[$];
  logic [23:0] acc;
  int          cnt;
  logic        tog = 1'b0;

  // Line readiness: prompt, every other cycle, or stalled.
  always @(posedge clk_i) tog <= ~tog;
  assign tx_bit_ready_o = !hold_i && (!slow_i || tog);

  // Bits of each octet arrive least significant first; a gap in valid ends a frame.
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt = 0;
      acc = '0;
    end else if (tx_bit_valid_i && tx_bit_ready_o) begin
      acc[cnt] = tx_bit_i;
      cnt++;
    end else if (!tx_bit_valid_i && cnt != 0) begin
      frames.push_back({8'(cnt), acc});
      cnt = 0;
      acc = '0;
    end
  end

  // Lines start idle.
  initial begin
    rx_valid_o = 1'b0;
    rx_addr_o  = 8'h00;
    rx_ctrl_o  = 16'h0000;
    rx_bad_o   = 1'b0;
  end

  // Offer one frame until taken, then leave inverted values on the released lines.
  // Only SABME is used for set-up, and REJ is sent only where the bench asks.
  task automatic send(input logic [7:0] a, input logic [15:0] c, input logic bad);
    @(posedge clk_i);
    #1;
    rx_valid_o = 1'b1;
    rx_addr_o  = a;
    rx_ctrl_o  = c;
    rx_bad_o   = bad;
    do @(negedge clk_i); while (!rx_ready_i);
    @(posedge clk_i);
    #1;
    rx_valid_o = 1'b0;
    rx_addr_o  = ~a;
    rx_ctrl_o  = ~c;
    rx_bad_o   = ~bad;
  endtask
endmodule // link_peer
